// [verilog/hme_pkg.sv]
/*
 * Constants for the monitor event-enable register slice: offsets,
 * reset values and bit positions.
 * Assumes an 8-bit register port with 8-bit offsets.
 */
package hme_pkg;
    // ************************************************************
    // Register offsets
    // ************************************************************
    localparam logic [7:0] OFS_SFR      = 8'h7C; // Special function
    localparam logic [7:0] OFS_CFG      = 8'h7F; // Configuration
    localparam logic [7:0] OFS_FTE      = 8'h80; // Fan/trip enable
    localparam logic [7:0] OFS_BIND     = 8'h81; // Tach to PWM binding
    localparam logic [7:0] OFS_THE      = 8'h82; // Thermal enable
    localparam logic [7:0] OFS_XSB      = 8'h84; // Standby/battery
    localparam logic [7:0] OFS_XDI      = 8'h85; // Diodes
    localparam logic [7:0] OFS_X12      = 8'h86; // 12 V / ambient
    localparam logic [7:0] OFS_X5       = 8'h87; // 5 V / 2.5 V
    localparam logic [7:0] OFS_XMC      = 8'h88; // Main / cpu supply
    localparam logic [7:0] OFS_XTP      = 8'h89; // Trip voltage
    localparam logic [7:0] OFS_TST      = 8'h8A; // Temperature tuning
    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [7:0] RST_FTE      = 8'h1E;
    localparam logic [7:0] RST_BIND     = 8'h24;
    localparam logic [7:0] RST_THE      = 8'h0E;
    localparam logic [7:0] RST_TST      = 8'hEE;
    localparam logic [7:0] RST_SFR      = 8'hE0;
    localparam logic [7:0] RST_CFG      = 8'h10;
    // ************************************************************
    // Bit positions
    // ************************************************************
    localparam int BIT_INIT   = 7;  // Soft reset, self-clearing
    localparam int BIT_IRQEN  = 2;  // Interrupt output enable
    localparam int BIT_MONMD  = 1;  // Monitoring mode
    localparam int BIT_GRP    = 0;  // Group enable in 80h and 82h
    localparam int BIT_TRIP   = 5;  // Trip voltage event enable
    localparam int BIT_T1     = 1;  // First tach/thermal enable
    // Reserved binding code
    localparam logic [1:0] BIND_RES = 2'h3;
    // Reading channel indices
    localparam int CH_BAT = 0;
    localparam int CH_STB = 1;
    localparam int CH_D1  = 2;
    localparam int CH_D2  = 3;
    localparam int CH_AMB = 4;
    localparam int CH_12V = 5;
    localparam int CH_2V5 = 6;
    localparam int CH_5V  = 7;
    localparam int CH_CPU = 8;
    localparam int CH_MN  = 9;
    localparam int CH_TRP = 10;
endpackage : hme_pkg

// [verilog/hme_event_enables.sv]
/*
 * Monitor event-enable slice: soft reset, event enables, tach to PWM
 * binding, extra-resolution nibble latches, limit compare, interrupt.
 * Assumes all inputs come from logic on clk_sys_i; the lock bit and
 * the status clear strobes are driven by the surrounding monitor.
 */
`timescale 1ns/1ps
// Function
// RL1: Config top bit starts self-clearing soft reset
// RL2: Soft reset defaults all except readings
// RL3: Lock makes slice registers read-only
// RL4: 80h bits enable tach and trip events
// RL5: Group tach enable gates interrupt
// RL6: Binding fields pick PWM, 11 reserved
// RL7: No tach event while bound duty zero
// RL8: No tach event while fan disabled
// RL9: No tach event with all-ones minimum
// RL10: Software sets unbound PWMs to mode one
// RL11: Software binds every tach to a PWM
// RL12: 82h bits enable thermal events
// RL13: Group thermal enable gates interrupt
// RL14: Ten-bit samples averaged into twelve bits
// RL15: Upper read latches lower nibble
// RL16: Nibble layout across 84h to 89h
// RL17: Upper byte compared against limits
// RL18: Software writes all ones to test register
// RL19: Special function bit enables interrupt
// RL20: Active-low interrupt from groups and status
module hme_event_enables
    import hme_pkg::*;
#(
    parameter int CH_N = 11
) (
    input  wire logic               clk_sys_i,
    input  wire logic               nrst_i,
    input  wire logic [7:0]         reg_addr_i,
    input  wire logic               reg_wr_i,
    input  wire logic               reg_rd_i,
    input  wire logic [7:0]         reg_wdata_i,
    output logic [7:0]              reg_rdata_o,
    input  wire logic               lock_i,
    input  wire logic [CH_N*12-1:0] avg_i,
    input  wire logic [CH_N-1:0]    upper_read_i,
    input  wire logic [CH_N*8-1:0]  lim_hi_i,
    input  wire logic [CH_N*8-1:0]  lim_lo_i,
    input  wire logic [2:0]         tach_low_i,
    input  wire logic [2:0]         tach_min_ones_i,
    input  wire logic [2:0]         fan_off_i,
    input  wire logic [2:0]         pwm_zero_i,
    input  wire logic [6:0]         stat_clr_i,
    output logic [6:0]              status_o,
    output logic [CH_N-1:0]         limit_viol_o,
    output logic                    soft_rst_o,
    output logic                    monitor_irq_n_o
);
    // ************************************************************
    // Elaboration check
    // ************************************************************
    // Nibble map is fixed to the eleven documented channels
    // A wider build would need a nibble map of its own
    if (CH_N != 11) begin : g_bad_ch
        $error("CH_N must be 11");
    end

    // ************************************************************
    // Helpers
    // ************************************************************
    // Duty-zero of the PWM a binding code names; reserved reads live
    function automatic logic bound_zero(input logic [1:0] sel,
                                        input logic [2:0] z);
        bound_zero = 1'b0;
        if (sel != BIND_RES) begin
            bound_zero = z[sel];
        end
    endfunction : bound_zero

    // Upper byte of a channel's averaged reading
    // Low nibble is the extra resolution, kept for the latches
    function automatic logic [7:0] upper(input int ch,
        input logic [CH_N*12-1:0] v);
        upper = v[ch*12+4 +: 8];                                  // RL14
    endfunction : upper

    // ************************************************************
    // State
    // ************************************************************
    // All storage is flops; nibbles form an array by channel
    logic [7:0]      fte;        // Fan/trip enable
    logic [7:0]      bind_r;     // Tach to PWM binding
    logic [7:0]      the;        // Thermal enable
    logic [7:0]      tst;        // Temperature tuning test
    logic            irq_output_enable; // Interrupt output enable
    logic            monmd;      // Monitoring mode select
    logic            init;       // Soft reset request
    logic [3:0]      nib [CH_N]; // Latched lower nibbles
    logic [6:0]      stat;       // Sticky event status
    logic [CH_N-1:0] viol;       // Registered limit violations
    logic            irq_n;      // Interrupt output flop
    logic [7:0]      rdata;      // Read data flop

    // ************************************************************
    // Decode
    // ************************************************************
    // Soft reset rides the same path as the pin reset
    wire rst_all = !nrst_i || init;                           // RL2
    // Writes are single-cycle strobes taken at the rising edge
    wire wr_ok   = reg_wr_i && !lock_i;                       // RL3
    // Per-register strobes; the nibble offsets have none
    wire wr_fte  = wr_ok && (reg_addr_i == OFS_FTE);
    wire wr_bind = wr_ok && (reg_addr_i == OFS_BIND);
    wire wr_the  = wr_ok && (reg_addr_i == OFS_THE);
    wire wr_tst  = wr_ok && (reg_addr_i == OFS_TST);
    wire wr_sfr  = wr_ok && (reg_addr_i == OFS_SFR);
    wire wr_cfg  = wr_ok && (reg_addr_i == OFS_CFG);

    // Limit compare on upper byte, outside either bound
    logic [CH_N-1:0] next_viol;
    always_comb begin
        for (int c = 0; c < CH_N; c++) begin
            next_viol[c] = (upper(c, avg_i) > lim_hi_i[c*8 +: 8]) ||
                           (upper(c, avg_i) < lim_lo_i[c*8 +: 8]); // RL17
        end
    end

    // Tach event qualifiers
    // Levels: a held fault sets a cleared bit again
    logic [2:0] tach_ev;
    always_comb begin
        for (int t = 0; t < 3; t++) begin
            tach_ev[t] = tach_low_i[t] && fte[BIT_T1+t]           // RL4
                && !bound_zero(bind_r[2*t +: 2], pwm_zero_i)      // RL7
                && !fan_off_i[t]                                  // RL8
                && !tach_min_ones_i[t];                           // RL9
        end
    end

    // Status order: tach1..3, trip, ambient, diode1, diode2
    // Trip has no group bit, so it never reaches the pin
    wire [6:0] set_ev = {
        viol[CH_D2]  && the[BIT_T1+2],                            // RL12
        viol[CH_D1]  && the[BIT_T1+1],
        viol[CH_AMB] && the[BIT_T1],
        viol[CH_TRP] && fte[BIT_TRIP],                            // RL4
        tach_ev};
    wire [6:0] next_stat = set_ev | (stat & ~stat_clr_i);

    // Group gating toward the interrupt pin
    // Ambient and both diodes share the thermal group
    wire tach_pend = fte[BIT_GRP] && |stat[2:0];                  // RL5
    wire temp_pend = the[BIT_GRP] && |stat[6:4];                  // RL13
    wire next_irq_n = !(irq_output_enable &&
                        (tach_pend || temp_pend));                // RL20

    // Read mux, address decoding as an if chain
    // Unmapped offsets fall through to zero
    // Captured only on a strobe, so reads have no side effects
    logic [7:0] next_rdata;
    always_comb begin
        next_rdata = 8'h00;
        if (reg_addr_i == OFS_FTE) begin
            next_rdata = fte;
        end else if (reg_addr_i == OFS_BIND) begin
            next_rdata = bind_r;
        end else if (reg_addr_i == OFS_THE) begin
            next_rdata = the;
        end else if (reg_addr_i == OFS_TST) begin
            next_rdata = tst;
        end else if (reg_addr_i == OFS_SFR) begin
            next_rdata = {RST_SFR[7:3], irq_output_enable, monmd, 1'b0};
        end else if (reg_addr_i == OFS_CFG) begin
            next_rdata = {init, RST_CFG[6:0]};
        end else if (reg_addr_i == OFS_XSB) begin
            next_rdata = {nib[CH_STB], nib[CH_BAT]};              // RL16
        end else if (reg_addr_i == OFS_XDI) begin
            next_rdata = {nib[CH_D2], nib[CH_D1]};
        end else if (reg_addr_i == OFS_X12) begin
            next_rdata = {nib[CH_12V], nib[CH_AMB]};
        end else if (reg_addr_i == OFS_X5) begin
            next_rdata = {nib[CH_5V], nib[CH_2V5]};
        end else if (reg_addr_i == OFS_XMC) begin
            next_rdata = {nib[CH_MN], nib[CH_CPU]};
        end else if (reg_addr_i == OFS_XTP) begin
            next_rdata = {4'h0, nib[CH_TRP]};
        end
    end

    // ************************************************************
    // Soft reset bit
    // ************************************************************
    // Held one cycle, then clears itself through rst_all
    // Lock also blocks the soft reset write
    always_ff @(posedge clk_sys_i) begin
        if (rst_all) begin
            init <= 1'b0;                                         // RL1
        end else if (wr_cfg) begin
            init <= reg_wdata_i[BIT_INIT];                        // RL1
        end
    end

    // ************************************************************
    // Enable, binding and test registers
    // ************************************************************
    // Reserved bits are masked on write so they read back zero once written
    // Lock is folded into the strobes, so no branch here sees it
    always_ff @(posedge clk_sys_i) begin
        if (rst_all) begin
            fte    <= RST_FTE;                                    // RL2
            bind_r <= RST_BIND;
            the    <= RST_THE;
            tst    <= RST_TST;
        end else begin
            if (wr_fte) begin
                fte <= reg_wdata_i & 8'h2F;                       // RL4
            end
            if (wr_bind) begin
                bind_r <= reg_wdata_i & 8'h3F;                    // RL6
            end
            if (wr_the) begin
                the <= reg_wdata_i & 8'h0F;                       // RL12
            end
            if (wr_tst) begin
                tst <= reg_wdata_i;
            end
        end
    end

    // Special function bits; output is off by default
    // Monitoring mode is kept for read-back only
    always_ff @(posedge clk_sys_i) begin
        if (rst_all) begin
            irq_output_enable <= RST_SFR[BIT_IRQEN];              // RL19
            monmd             <= RST_SFR[BIT_MONMD];
        end else if (wr_sfr) begin
            irq_output_enable <= reg_wdata_i[BIT_IRQEN];          // RL19
            monmd             <= reg_wdata_i[BIT_MONMD];
        end
    end

    // ************************************************************
    // Nibble latches
    // ************************************************************
    // Reading data survives soft reset, so only the pin reset clears
    // Latched on the read pulse so both halves of a value pair up
    always_ff @(posedge clk_sys_i) begin
        for (int c = 0; c < CH_N; c++) begin
            if (!nrst_i) begin
                nib[c] <= 4'h0;
            end else if (upper_read_i[c]) begin
                nib[c] <= avg_i[c*12 +: 4];                       // RL15
            end
        end
    end

    // ************************************************************
    // Status, compare, interrupt and read data flops
    // ************************************************************
    // Set beats a clear in the same cycle
    // Compare is registered to keep it off the status set path
    // Read data only moves on a read strobe or a reset
    always_ff @(posedge clk_sys_i) begin
        if (rst_all) begin
            stat  <= 7'h00;
            viol  <= '0;
            irq_n <= 1'b1;
            rdata <= 8'h00;
        end else begin
            stat  <= next_stat;
            viol  <= next_viol;                                   // RL17
            irq_n <= next_irq_n;                                  // RL20
            rdata <= reg_rd_i ? next_rdata : rdata;
        end
    end

    assign reg_rdata_o     = rdata;
    assign status_o        = stat;
    assign limit_viol_o    = viol;
    assign soft_rst_o      = init;
    assign monitor_irq_n_o = irq_n;

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!nrst_i);

    // Soft reset and lock
    AST_INIT_CLEARS: assert property (init |=> !init) // RL1
        else $error("soft reset bit did not clear");
    AST_SOFT_DEF: assert property ( // RL2
        init |=> fte == RST_FTE && bind_r == RST_BIND && the == RST_THE)
        else $error("soft reset did not restore defaults");
    AST_NIB_KEEP: assert property ( // RL2
        init && !upper_read_i[CH_D1] |=> $stable(nib[CH_D1]))
        else $error("soft reset touched a nibble");
    AST_LOCK: assert property ( // RL3
        lock_i && !init
        |=> $stable(fte) && $stable(bind_r) && $stable(the))
        else $error("locked register changed");
    // Tach qualifiers; all but the binding check start from a clear status bit
    AST_TACH_EN: assert property ( // RL4
        !fte[BIT_T1] && !stat[0] && !init |=> !stat[0])
        else $error("disabled tach set status");
    AST_BIND_SEL: assert property ( // RL6
        bind_r[1:0] == 2'b01 && !pwm_zero_i[1] && tach_low_i[0]
        && fte[BIT_T1] && !fan_off_i[0] && !tach_min_ones_i[0]
        && !init |=> stat[0])
        else $error("binding picked the wrong PWM");
    AST_DUTY0: assert property ( // RL7
        bind_r[1:0] != BIND_RES && pwm_zero_i[bind_r[1:0]]
        && !stat[0] && !stat_clr_i[0] && !init |=> !stat[0])
        else $error("tach event with zero duty");
    AST_FANOFF: assert property ( // RL8
        fan_off_i[0] && !stat[0] && !init |=> !stat[0])
        else $error("tach event with fan off");
    AST_MINONES: assert property ( // RL9
        tach_min_ones_i[0] && !stat[0] && !init |=> !stat[0])
        else $error("tach event with all-ones minimum");
    // Thermal events, nibble latching and compare
    AST_THERM: assert property ( // RL12
        viol[CH_AMB] && the[BIT_T1] && !init |=> stat[4])
        else $error("ambient event lost");
    AST_LATCH: assert property ( // RL15
        upper_read_i[CH_TRP] && !init
        |=> nib[CH_TRP] == $past(avg_i[CH_TRP*12 +: 4]))
        else $error("nibble not latched");
    AST_MAP: assert property ( // RL16
        reg_rd_i && reg_addr_i == OFS_XDI && !init
        |=> reg_rdata_o == {$past(nib[CH_D2]), $past(nib[CH_D1])})
        else $error("nibble layout wrong");
    AST_CMP: assert property ( // RL17
        !init ##1 !init |-> limit_viol_o[CH_D2] ==
        ($past(avg_i[CH_D2*12+4 +: 8]) > $past(lim_hi_i[CH_D2*8 +: 8]) ||
         $past(avg_i[CH_D2*12+4 +: 8]) < $past(lim_lo_i[CH_D2*8 +: 8])))
        else $error("limit compare wrong");
    // Interrupt pin, registered one cycle behind its causes
    AST_IRQ_OFF: assert property ( // RL19
        !irq_output_enable && !init |=> monitor_irq_n_o)
        else $error("interrupt while output disabled");
    AST_IRQ_GRP: assert property ( // RL5
        irq_output_enable && fte[BIT_GRP] && stat[0] && !init
        |=> !monitor_irq_n_o)
        else $error("tach group did not assert interrupt");
    AST_IRQ_TMP: assert property ( // RL13
        !the[BIT_GRP] && !fte[BIT_GRP] && !init |=> monitor_irq_n_o)
        else $error("interrupt with groups off");
    AST_IRQ_SET: assert property ( // RL20
        irq_output_enable && the[BIT_GRP] && stat[5] && !init
        |=> !monitor_irq_n_o)
        else $error("thermal group did not assert interrupt");

    // Main scenarios
    COV_SOFT: cover property (wr_cfg && reg_wdata_i[BIT_INIT]);
    COV_IRQ: cover property ($fell(monitor_irq_n_o));
    COV_LOCKED: cover property (lock_i && reg_wr_i);
    COV_SUPP: cover property (tach_low_i[0] && pwm_zero_i[0]);
    COV_THERM: cover property (stat[5] && the[BIT_GRP]);
endmodule : hme_event_enables

// [sim/test_hw_monitor_event_enables.sv]
/*
 * Self-checking bench for the monitor event-enable slice: registers,
 * lock, nibble latches, limit compare, tach gating, irq and soft reset.
 * Assumes one clock; all inputs are driven here at the falling edge.
 */
`timescale 1ns/1ps
module test_hw_monitor_event_enables
    import hme_pkg::*;
;
    localparam int CH_N = 11;
    // ************************************************************
    // Stimulus and observed signals
    // ************************************************************
    logic                    clk = 1'b0;   // 200 MHz system clock
    logic                    nrst = 1'b0;  // Sync reset, active low
    logic [7:0]              addr = '0;    // Register offset
    logic                    wr = 1'b0;    // Write strobe
    logic                    rd = 1'b0;    // Read strobe
    logic [7:0]              wdata = '0;   // Write data
    logic                    lock = 1'b0;  // Lock level
    logic [CH_N*12-1:0]      avg = '0;     // Averaged readings
    logic [CH_N-1:0]         upr = '0;     // Upper-byte read pulses
    logic [CH_N*8-1:0]       lhi = '1;     // High limits
    logic [CH_N*8-1:0]       llo = '0;     // Low limits
    logic [2:0]              tlow = '0, tmin = '0, foff = '0, pz = '0;
    logic [6:0]              sclr = '0;    // Status clear pulses
    logic [7:0]              rdata;
    logic [6:0]              status;
    logic [CH_N-1:0]         viol;
    logic                    srst, irq_n;
    int                      fail_count = 0;
    int                      tests_run = 0;
    int                      mdl[int];     // Model of the register file
    int                      nib[CH_N];    // Model of latched nibbles
    logic [7:0]              rv, ex;
    logic [7:0]              al[8] = '{8'h7C, 8'h80, 8'h81, 8'h82,
                                       8'h8A, 8'h83, 8'h84, 8'h89};
    int                      tb[5][4] = '{'{1, 0, 0, 1}, '{2, 0, 0, 0},
                                          '{0, 1, 0, 0}, '{0, 0, 1, 0},
                                          '{0, 0, 0, 1}};

    hme_event_enables #(.CH_N(CH_N)) dut (
        .clk_sys_i(clk), .nrst_i(nrst), .reg_addr_i(addr),
        .reg_wr_i(wr), .reg_rd_i(rd), .reg_wdata_i(wdata),
        .reg_rdata_o(rdata), .lock_i(lock), .avg_i(avg),
        .upper_read_i(upr), .lim_hi_i(lhi), .lim_lo_i(llo),
        .tach_low_i(tlow), .tach_min_ones_i(tmin), .fan_off_i(foff),
        .pwm_zero_i(pz), .stat_clr_i(sclr), .status_o(status),
        .limit_viol_o(viol), .soft_rst_o(srst), .monitor_irq_n_o(irq_n)
    );

    // Free-running clock, 5 ns period
    initial begin
        forever #2.5 clk = ~clk;
    end

    // Hang guard: a stuck run counts as a mismatch
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        close_out();
    end

    // ************************************************************
    // Shared tasks
    // ************************************************************
    task automatic close_out();
        if (fail_count == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : close_out

    task automatic chk(input string nm, input logic [31:0] seen, exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    // Defaults that reset and soft reset restore
    task automatic mdl_rst();
        mdl[8'h7C] = 8'hE0; mdl[8'h7F] = 8'h10; mdl[8'h80] = 8'h1E;
        mdl[8'h81] = 8'h24; mdl[8'h82] = 8'h0E; mdl[8'h8A] = 8'hEE;
    endtask : mdl_rst

    // Expected read value; unmapped offsets read zero
    function automatic int exp_rd(input int a);
        case (a)
            8'h84: return nib[CH_STB] * 16 + nib[CH_BAT];
            8'h85: return nib[CH_D2] * 16 + nib[CH_D1];
            8'h86: return nib[CH_12V] * 16 + nib[CH_AMB];
            8'h87: return nib[CH_5V] * 16 + nib[CH_2V5];
            8'h88: return nib[CH_MN] * 16 + nib[CH_CPU];
            8'h89: return nib[CH_TRP];
            default: return mdl.exists(a) ? mdl[a] : 0;
        endcase
    endfunction : exp_rd

    // One-cycle write strobe, released at the next falling edge
    task automatic wr_bus(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        addr = a; wdata = d; wr = 1'b1;
        @(negedge clk);
        wr = 1'b0;
    endtask : wr_bus

    // Write through bus and model; lock leaves the model untouched
    task automatic mwr(input logic [7:0] a, input logic [7:0] d);
        wr_bus(a, d);
        if (!lock) begin
            case (a)
                8'h7C: mdl[a] = 8'hE0 | (d & 8'h06);
                8'h80: mdl[a] = d & 8'h2F;
                8'h81: mdl[a] = d & 8'h3F;
                8'h82: mdl[a] = d & 8'h0F;
                8'h8A: mdl[a] = d;
                default: ;
            endcase
        end
    endtask : mwr

    // Read, then compare with the model
    task automatic rchk(input logic [7:0] a);
        @(negedge clk);
        addr = a; rd = 1'b1;
        @(negedge clk);
        rd = 1'b0;
        chk($sformatf("reg %h", a), rdata, exp_rd(a));
    endtask : rchk

    task automatic clr_status();
        sclr = 7'h7F;
        repeat (3) @(negedge clk);
        sclr = '0;
        @(negedge clk);
    endtask : clr_status

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        void'($urandom(9591));
        mdl_rst();
        foreach (nib[c]) nib[c] = 0;
        repeat (4) @(negedge clk);
        nrst = 1'b1;
        for (int a = 8'h7C; a <= 8'h8B; a++) rchk(8'(a));
        // Random writes, then the same under lock
        for (int i = 0; i < 32; i++) begin
            lock = (i >= 16);
            ex = al[$urandom % 8];
            mwr(ex, 8'($urandom));
            rchk(ex);
        end
        lock = 1'b0;
        mwr(8'h8A, 8'hFF);
        // Nibble latching and limit compare with random readings
        repeat (6) begin
            @(negedge clk);
            avg = (CH_N*12)'({$urandom, $urandom, $urandom, $urandom,
                              $urandom});
            lhi = (CH_N*8)'({$urandom, $urandom, $urandom});
            llo = (CH_N*8)'({$urandom, $urandom, $urandom});
            upr = CH_N'($urandom);
            for (int c = 0; c < CH_N; c++) begin
                if (upr[c]) nib[c] = avg[c*12 +: 4];
            end
            @(negedge clk);
            upr = '0;
            avg = ~avg;
            @(negedge clk);
            for (int c = 0; c < CH_N; c++) begin
                ex = avg[c*12+4 +: 8];
                chk("viol", viol[c], ex > lhi[c*8 +: 8] || ex < llo[c*8 +: 8]);
            end
            for (int a = 8'h84; a <= 8'h89; a++) rchk(8'(a));
        end
        // Tach gating: tach 1 bound to PWM 2
        lhi = '1; llo = '0;
        repeat (3) @(negedge clk);
        clr_status();
        mwr(8'h7C, 8'h04); mwr(8'h80, 8'h0F); mwr(8'h81, 8'h01);
        mwr(8'h82, 8'h0E);
        foreach (tb[k]) begin
            pz = 3'(tb[k][0]); foff[0] = tb[k][1][0]; tmin[0] = tb[k][2][0];
            tlow[0] = 1'b1;
            repeat (3) @(negedge clk);
            chk("tach status", status[0], tb[k][3][0]);
            chk("irq", irq_n, !tb[k][3][0]);
            tlow = '0; pz = '0; foff = '0; tmin = '0;
            clr_status();
            chk("irq cleared", irq_n, 1'b1);
        end
        // Group off, output off, individual enable off
        for (int k = 0; k < 3; k++) begin
            mwr(8'h7C, k == 1 ? 8'h00 : 8'h04);
            mwr(8'h80, k == 0 ? 8'h0E : (k == 1 ? 8'h0F : 8'h0D));
            tlow[0] = 1'b1;
            repeat (3) @(negedge clk);
            chk("tach status", status[0], k != 2);
            chk("irq", irq_n, 1'b1);
            tlow = '0;
            clr_status();
        end
        // Ambient and trip over limit, thermal group off then on
        mwr(8'h7C, 8'h04); mwr(8'h80, 8'h20);
        avg[CH_AMB*12 +: 12] = 12'h800; lhi[CH_AMB*8 +: 8] = 8'h10;
        avg[CH_TRP*12 +: 12] = 12'h800; lhi[CH_TRP*8 +: 8] = 8'h10;
        avg[CH_D1*12 +: 12] = 12'h800; lhi[CH_D1*8 +: 8] = 8'h10;
        repeat (4) @(negedge clk);
        chk("amb status", status[4], 1'b1);
        chk("trip status", status[3], 1'b1);
        chk("diode1 status", status[5], 1'b1);
        chk("irq", irq_n, 1'b1);
        mwr(8'h82, 8'h0F);
        repeat (2) @(negedge clk);
        chk("irq", irq_n, 1'b0);
        // Soft reset keeps nibbles, restores the rest
        wr_bus(8'h7F, 8'h80);
        chk("soft reset", srst, 1'b1);
        @(negedge clk);
        chk("soft reset end", srst, 1'b0);
        mdl_rst();
        chk("status", status, 7'h00);
        chk("irq", irq_n, 1'b1);
        for (int a = 8'h7C; a <= 8'h8B; a++) rchk(8'(a));
        close_out();
    end
endmodule : test_hw_monitor_event_enables
